// file: dacreg_pkg.sv
`default_nettype none
package dacreg_pkg;
  localparam logic [7:0] OFS_DAC_CFG = 8'h1B;
  localparam logic [7:0] OFS_LOAD = 8'h1C;
  localparam logic [7:0] OFS_MASK1 = 8'h1D;
  localparam logic [7:0] OFS_MASK2 = 8'h1E;
  localparam logic [7:0] OFS_TEMP_OFS = 8'h1F;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int POLICY_LSB = 4;
  localparam int REF_AB_BIT = 4;
  localparam int REF_CD_BIT = 5;
  localparam int SUPPLY_MASK_BIT = 4;
  localparam int TEMP_W = 10;
  localparam int TEMP_FRAC = 2;
  typedef enum logic [1:0] {
    DACREG_POL_SINGLE = 2'b00,
    DACREG_POL_PAIR = 2'b01,
    DACREG_POL_ALL = 2'b10,
    DACREG_POL_STROBE = 2'b11
  } dacreg_policy_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } dacreg_write_t;
  typedef struct packed {
    logic int_high;
    logic int_low;
    logic ext_high;
    logic ext_low;
    logic ext_fault;
    logic analog_input_two;
    logic analog_input_three;
    logic analog_input_four;
    logic supply;
  } dacreg_events_t;
endpackage
`default_nettype wire

// file: dacreg_top.sv
`default_nettype none
module dacreg_top
  import dacreg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire dacreg_write_t reg_wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic pin_load_disable_bit,
  input wire logic dac_load_strobe_n,
  input wire logic [3:0] dac_msb_write,
  input wire dacreg_events_t events_in,
  input wire logic temp_valid,
  input wire logic [TEMP_W-1:0] temp_raw,
  output logic [TEMP_W-1:0] temp_result,
  output logic temp_result_valid,
  output logic [3:0] dac_update,
  output logic [3:0] dac_range,
  output logic [1:0] dac_ref_internal,
  output logic int_active
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] dac_range_and_update_policy;
  logic [1:0] ref_sel;
  logic [7:0] interrupt_mask_first;
  logic [7:0] interrupt_mask_second;
  logic [7:0] internal_temp_offset;
  logic [1:0] pin_sync;
  logic pin_prev;
  logic [3:0] next_update;
  logic [1:0] policy;
  logic pin_fall;

  assign policy = dac_range_and_update_policy[POLICY_LSB+1:POLICY_LSB];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dac_range_and_update_policy <= RESET_VALUE;
      ref_sel <= 2'b00;
      interrupt_mask_first <= RESET_VALUE;
      interrupt_mask_second <= RESET_VALUE;
      internal_temp_offset <= RESET_VALUE;
    end else if (reg_wr.wr) begin
      case (reg_wr.addr)
        OFS_DAC_CFG: dac_range_and_update_policy <= reg_wr.data;
        OFS_LOAD: ref_sel <= {reg_wr.data[REF_CD_BIT], reg_wr.data[REF_AB_BIT]};
        OFS_MASK1: interrupt_mask_first <= reg_wr.data;
        OFS_MASK2: interrupt_mask_second <= reg_wr.data;
        OFS_TEMP_OFS: internal_temp_offset <= reg_wr.data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  // strobe bits never stored, so they read as zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data <= RESET_VALUE;
    end else begin
      case (rd_addr)
        OFS_DAC_CFG: rd_data <= dac_range_and_update_policy;
        OFS_LOAD: rd_data <= {2'b00, ref_sel, 4'h0};
        OFS_MASK1: rd_data <= interrupt_mask_first;
        OFS_MASK2: rd_data <= interrupt_mask_second;
        OFS_TEMP_OFS: rd_data <= internal_temp_offset;
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // update command
  // ----------------------------------------
  // load pin is asynchronous, so synchronise before edge detect
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_sync <= 2'b11;
      pin_prev <= 1'b1;
    end else begin
      pin_sync <= {pin_sync[0], dac_load_strobe_n};
      pin_prev <= pin_sync[1];
    end
  end
  assign pin_fall = pin_prev & ~pin_sync[1];

  always_comb begin
    next_update = 4'h0;
    if (!pin_load_disable_bit) begin
      next_update = pin_fall ? 4'hF : 4'h0;
    end else begin
      case (policy)
        DACREG_POL_SINGLE: next_update = dac_msb_write;
        DACREG_POL_PAIR: next_update = {{2{dac_msb_write[3]}}, {2{dac_msb_write[1]}}};
        DACREG_POL_ALL: next_update = {4{dac_msb_write[3]}};
        DACREG_POL_STROBE: begin
          if (reg_wr.wr && reg_wr.addr == OFS_LOAD) begin
            next_update = reg_wr.data[3:0];
          end
        end
        default: next_update = 4'h0;
      endcase
    end
  end

  // one pulse moves all targeted input latches together
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dac_update <= 4'h0;
      dac_range <= 4'h0;
      dac_ref_internal <= 2'b00;
    end else begin
      dac_update <= next_update;
      dac_range <= dac_range_and_update_policy[3:0];
      dac_ref_internal <= ref_sel;
    end
  end

  // ----------------------------------------
  // interrupt gating
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_active <= 1'b0;
    end else begin
      int_active <= (events_in.int_high & ~interrupt_mask_first[0])
        | (events_in.int_low & ~interrupt_mask_first[1])
        | (events_in.ext_high & ~interrupt_mask_first[2])
        | (events_in.ext_low & ~interrupt_mask_first[3])
        | (events_in.ext_fault & ~interrupt_mask_first[4])
        | (events_in.analog_input_two & ~interrupt_mask_first[5])
        | (events_in.analog_input_three & ~interrupt_mask_first[6])
        | (events_in.analog_input_four & ~interrupt_mask_first[7])
        | (events_in.supply & ~interrupt_mask_second[SUPPLY_MASK_BIT]);
    end
  end

  // ----------------------------------------
  // temperature offset
  // ----------------------------------------
  // result has quarter-degree lsbs; offset lsb is one degree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      temp_result <= '0;
      temp_result_valid <= 1'b0;
    end else begin
      temp_result_valid <= temp_valid;
      if (temp_valid) begin
        temp_result <= temp_raw + TEMP_W'({internal_temp_offset, {TEMP_FRAC{1'b0}}});
      end
    end
  end

  // ----------------------------------------
  // checks: registers
  // ----------------------------------------
  a_cfg_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr.wr && reg_wr.addr == OFS_DAC_CFG)
    |=> dac_range_and_update_policy == $past(reg_wr.data))
    else $error("dac configuration write not stored");

  a_cfg_readback: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_addr == OFS_DAC_CFG)
    |=> rd_data == $past(dac_range_and_update_policy))
    else $error("dac configuration readback wrong");

  a_range_follows: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1
    |=> dac_range == $past(dac_range_and_update_policy[3:0]))
    else $error("dac range does not follow register");

  a_load_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_addr == OFS_LOAD)
    |=> rd_data[3:0] == 4'h0)
    else $error("strobe bits read non-zero");

  a_ref_ab_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr.wr && reg_wr.addr == OFS_LOAD)
    |=> ref_sel[0] == $past(reg_wr.data[REF_AB_BIT]))
    else $error("reference select for a and b not stored");

  a_ref_cd_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr.wr && reg_wr.addr == OFS_LOAD)
    |=> ref_sel[1] == $past(reg_wr.data[REF_CD_BIT]))
    else $error("reference select for c and d not stored");

  a_ref_follows: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1
    |=> dac_ref_internal == $past(ref_sel))
    else $error("reference output does not follow register");

  a_mask1_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr.wr && reg_wr.addr == OFS_MASK1)
    |=> interrupt_mask_first == $past(reg_wr.data))
    else $error("first mask write not stored");

  a_mask2_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr.wr && reg_wr.addr == OFS_MASK2)
    |=> interrupt_mask_second == $past(reg_wr.data))
    else $error("second mask write not stored");

  a_offset_write: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr.wr && reg_wr.addr == OFS_TEMP_OFS)
    |=> internal_temp_offset == $past(reg_wr.data))
    else $error("temperature offset write not stored");

  a_offset_readback: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_addr == OFS_TEMP_OFS)
    |=> rd_data == $past(internal_temp_offset))
    else $error("temperature offset readback wrong");

  // ----------------------------------------
  // checks: update command
  // ----------------------------------------
  a_single_policy: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_load_disable_bit && policy == DACREG_POL_SINGLE)
    |=> dac_update == $past(dac_msb_write))
    else $error("single policy updated wrong dacs");

  a_pair_policy: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_load_disable_bit && policy == DACREG_POL_PAIR)
    |=> dac_update == {{2{$past(dac_msb_write[3])}}, {2{$past(dac_msb_write[1])}}})
    else $error("pair policy updated wrong dacs");

  a_all_policy: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_load_disable_bit && policy == DACREG_POL_ALL && dac_msb_write[3])
    |=> dac_update == 4'hF)
    else $error("policy all did not update four dacs");

  a_all_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_load_disable_bit && policy == DACREG_POL_ALL && !dac_msb_write[3])
    |=> dac_update == 4'h0)
    else $error("policy all updated without dac d write");

  a_strobe_only: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_load_disable_bit && policy == DACREG_POL_STROBE
     && !(reg_wr.wr && reg_wr.addr == OFS_LOAD))
    |=> dac_update == 4'h0)
    else $error("strobe policy updated without strobe");

  a_strobe_acts: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_load_disable_bit && policy == DACREG_POL_STROBE
     && reg_wr.wr && reg_wr.addr == OFS_LOAD)
    |=> dac_update == $past(reg_wr.data[3:0]))
    else $error("strobe did not update its dac");

  a_strobe_gated: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_wr.wr && reg_wr.addr == OFS_LOAD && (policy != DACREG_POL_STROBE)
     && pin_load_disable_bit && dac_msb_write == 4'h0)
    |=> dac_update == 4'h0)
    else $error("load strobe acted outside strobe policy");

  a_pin_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (!pin_load_disable_bit && !pin_fall)
    |=> dac_update == 4'h0)
    else $error("register path updated in pin mode");

  a_pin_fall_all: assert property (@(posedge clk) disable iff (!reset_n)
    (!pin_load_disable_bit && pin_fall)
    |=> dac_update == 4'hF)
    else $error("load pin edge did not update four dacs");

  // ----------------------------------------
  // checks: interrupt and temperature
  // ----------------------------------------
  a_mask_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    (interrupt_mask_first == 8'hFF && interrupt_mask_second[SUPPLY_MASK_BIT])
    |=> !int_active)
    else $error("masked interrupt reached output");

  a_int_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (events_in == '0)
    |=> !int_active)
    else $error("interrupt active with no event");

  a_int_temp_open: assert property (@(posedge clk) disable iff (!reset_n)
    ((events_in.int_high && !interrupt_mask_first[0])
     || (events_in.ext_low && !interrupt_mask_first[3]))
    |=> int_active)
    else $error("unmasked temperature event lost");

  a_int_fault_open: assert property (@(posedge clk) disable iff (!reset_n)
    (events_in.ext_fault && !interrupt_mask_first[4])
    |=> int_active)
    else $error("unmasked sensor fault lost");

  a_int_ain_open: assert property (@(posedge clk) disable iff (!reset_n)
    ((events_in.analog_input_two && !interrupt_mask_first[5])
     || (events_in.analog_input_four && !interrupt_mask_first[7]))
    |=> int_active)
    else $error("unmasked analog input event lost");

  a_int_supply_open: assert property (@(posedge clk) disable iff (!reset_n)
    (events_in.supply && !interrupt_mask_second[SUPPLY_MASK_BIT])
    |=> int_active)
    else $error("unmasked supply event lost");

  a_temp_valid: assert property (@(posedge clk) disable iff (!reset_n)
    temp_valid
    |=> temp_result_valid)
    else $error("temperature result valid missing");

  a_temp_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !temp_valid
    |=> (!temp_result_valid && temp_result == $past(temp_result)))
    else $error("temperature result moved without input");

  a_temp_sum: assert property (@(posedge clk) disable iff (!reset_n)
    temp_valid
    |=> temp_result == $past(temp_raw)
      + TEMP_W'({$past(internal_temp_offset), {TEMP_FRAC{1'b0}}}))
    else $error("temperature offset not applied in whole degrees");
endmodule
`default_nettype wire

// file: dacreg_host.sv
`default_nettype none
// ----------------------------------------
// host side of the register write port
// ----------------------------------------
module dacreg_host
  import dacreg_pkg::*;
(
  input wire logic clk,
  output var dacreg_write_t reg_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_wr = '0;
  // strobe held one edge only, so no write is ever taken twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_wr <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clk) reg_wr.wr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dacreg_pkg::*;
  logic clk, reset_n, dis, pin_n, tv, tv_out, ia;
  logic [7:0] rd_addr, rd_data;
  logic [3:0] msb, upd_o, rng, u;
  logic [1:0] refi;
  logic [8:0] ev;
  logic [9:0] traw, tres;
  dacreg_write_t reg_wr;
  int fail_count = 0, total_checks = 0, cycles = 0;
  logic [7:0] ofs [5] = '{OFS_DAC_CFG, OFS_LOAD, OFS_MASK1, OFS_MASK2, OFS_TEMP_OFS};
  dacreg_host host (.clk(clk), .reg_wr(reg_wr));
  dacreg_top dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .rd_addr(rd_addr),
    .rd_data(rd_data), .pin_load_disable_bit(dis), .dac_load_strobe_n(pin_n),
    .dac_msb_write(msb), .events_in(ev), .temp_valid(tv), .temp_raw(traw),
    .temp_result(tres), .temp_result_valid(tv_out), .dac_update(upd_o),
    .dac_range(rng), .dac_ref_internal(refi), .int_active(ia));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) rd_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("rd_data", {2'h0, e}, {2'h0, rd_data});
  endtask
  // expected update set per policy and written dac
  function automatic logic [3:0] upd(input int p, input int i);
    case (p)
      0: return 4'h1 << i;
      1: return i == 1 ? 4'h3 : (i == 3 ? 4'hC : 4'h0);
      2: return i == 3 ? 4'hF : 4'h0;
      default: return 4'h0;
    endcase
  endfunction
  task automatic pulse(input int i, input logic [3:0] e);
    @(posedge clk) msb <= 4'h1 << i;
    @(posedge clk) msb <= 4'h0;
    #1 chk("dac_update", {6'h00, e}, {6'h00, upd_o});
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0; rd_addr = '0; dis = 1'b1; pin_n = 1'b1; msb = '0;
    ev = '0; tv = 1'b0; traw = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    host.wr(OFS_DAC_CFG, 8'h0A);
    @(posedge clk);
    #1 chk("dac_range", 10'h00A, {6'h00, rng});
    rd(OFS_DAC_CFG, 8'h0A);
    host.wr(OFS_LOAD, 8'h0F);
    #1 chk("strobe_gated", 10'h000, {6'h00, upd_o});
    for (int p = 0; p < 4; p++) begin
      host.wr(OFS_DAC_CFG, 8'(p << POLICY_LSB));
      for (int i = 0; i < 4; i++) pulse(i, upd(p, i));
    end
    for (int i = 0; i < 4; i++) begin
      host.wr(OFS_LOAD, 8'h01 << i);
      #1 chk("strobe", 10'h001 << i, {6'h00, upd_o});
    end
    host.wr(OFS_LOAD, 8'h30);
    @(posedge clk);
    #1 chk("ref_sel", 10'h003, {8'h00, refi});
    rd(OFS_LOAD, 8'h30);
    // pin mode: register paths must stay silent
    @(posedge clk) dis <= 1'b0;
    host.wr(OFS_LOAD, 8'h0F);
    #1 chk("pin_mode", 10'h000, {6'h00, upd_o});
    host.wr(OFS_DAC_CFG, 8'h00);
    pulse(0, 4'h0);
    @(posedge clk) pin_n <= 1'b0;
    u = '0;
    repeat (6) begin
      @(posedge clk);
      #1 u |= upd_o;
    end
    chk("pin_load", 10'h00F, {6'h00, u});
    for (int k = 0; k < 9; k++) begin
      @(posedge clk) ev <= 9'h100 >> k;
      host.wr(OFS_MASK1, k < 8 ? 8'h01 << k : 8'h00);
      host.wr(OFS_MASK2, k < 8 ? 8'h00 : 8'h10);
      repeat (2) @(posedge clk);
      #1 chk("int_masked", 10'h000, {9'h000, ia});
      host.wr(OFS_MASK1, k < 8 ? ~(8'h01 << k) : 8'hFF);
      host.wr(OFS_MASK2, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk("int_open", 10'h001, {9'h000, ia});
    end
    host.wr(OFS_TEMP_OFS, 8'hFE);
    rd(OFS_TEMP_OFS, 8'hFE);
    @(posedge clk) tv <= 1'b1;
    traw <= 10'h064;
    @(posedge clk) tv <= 1'b0;
    #1 chk("temp_valid", 10'h001, {9'h000, tv_out});
    chk("temp_result", 10'h05C, tres);
    conclude();
  end
endmodule
`default_nettype wire
